// file: pkg/isa_consts.svh
// constants for the two-wire slave with arbitration
// assumes a 10 MHz system clock; included by bare name
`ifndef ISA_CONSTS_SVH
`define ISA_CONSTS_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ISA_CLK_MHZ 10
`define ISA_T_LOW_NS 4700
`define ISA_T_HIGH_NS 4000
// least times, rounded up to whole cycles
`define ISA_LOW_CYC ((`ISA_T_LOW_NS*`ISA_CLK_MHZ+999)/1000)
`define ISA_HIGH_CYC ((`ISA_T_HIGH_NS*`ISA_CLK_MHZ+999)/1000)
// ----------------------------------------------------------------
// framing and addresses
// ----------------------------------------------------------------
`define ISA_BYTE_BITS 4'h8
`define ISA_LAST_TX_BIT 4'h7
`define ISA_TEN_PREFIX 5'h1e
`define ISA_BIT_ZERO 4'h0
`define ISA_TMR_ZERO 8'h00
`define ISA_TMR_ONE 8'h01
`define ISA_SHIFT_AT 8'h02
`define ISA_ADDR_RST 8'h00
`define ISA_BYTE_RST 8'h00
`endif

// file: pkg/isa_pkg.sv
// state types for the two-wire slave with arbitration
// assumes no other package; used by rtl/isa_slave.sv
`default_nettype none
package isa_pkg;
  typedef enum logic [2:0] {
    SL_IDLE, SL_RX, SL_ACK, SL_TX, SL_TXACK
  } isa_sl_state_t;
  typedef enum logic [1:0] {
    PH_A1, PH_A2, PH_DAT
  } isa_phase_t;
  typedef enum logic [2:0] {
    M_IDLE, M_START, M_LOW, M_WAITH, M_HIGH
  } isa_mst_state_t;
endpackage
`default_nettype wire

// file: rtl/isa_slave.sv
// two-wire bus slave with multi-master arbitration and clock sync
// assumes scl/sda are open-drain pins resolved outside; flags are ports
//
// Functional notes
// - while transmitting, slave drives data onto the pins despite input setup
// - on match or data byte, acknowledge then copy shift register to buffer
// - buffer full or overflow set: no acknowledge, no load, still irq
// - buffer-full clears on buffer read; overflow clears only by software
// - once enabled, wait for START then shift eight bits in
// - every incoming bit sampled on rising clock edge
// - shift bits seven to one compared to own address on eighth fall
// - on clean match load buffer, set full, acknowledge, irq on ninth fall
// - ten-bit first byte is prefix, A9, A8, write bit
// - ten-bit address bytes set flags and stretch clock until address rewrite
// - after repeated START, high byte sets only irq and buffer-full
// - arbitration on data while clock high; loser stops driving data
// - loser clocks to byte end and receives as slave at once
// - no START or STOP contended against data or each other
// - clock falling edge starts low count; hold clock low until done
// - early finisher waits for clock high, then times high, first pulls low
`timescale 1ns/10ps
`default_nettype none
`include "isa_consts.svh"
module isa_slave #(
  parameter int LOW_CYC = `ISA_LOW_CYC,
  parameter int HIGH_CYC = `ISA_HIGH_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // software control
  input wire logic enable,
  input wire logic ten_bit_mode,
  input wire logic own_addr_wr,
  input wire logic [7:0] own_addr_wdata,
  input wire logic buf_rd,
  input wire logic ovf_clr,
  input wire logic irq_clr,
  input wire logic [7:0] tx_data,
  // software status
  output logic [7:0] receive_buffer,
  output logic [7:0] own_address_register,
  output logic buffer_full_flag,
  output logic receive_overflow_flag,
  output logic serial_port_irq_flag,
  output logic address_update_flag,
  output logic read_mode,
  // master side
  input wire logic mst_go,
  input wire logic [7:0] mst_byte,
  output logic mst_busy,
  output logic arb_lost
);
  // ----------------------------------------------------------------
  // pin synchronisers and bus events
  // ----------------------------------------------------------------
  logic [2:0] scl_sh_q;
  logic [2:0] sda_sh_q;
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_sh_q <= 3'h7;
      sda_sh_q <= 3'h7;
    end else begin
      scl_sh_q <= {scl_sh_q[1:0], scl_in};
      sda_sh_q <= {sda_sh_q[1:0], sda_in};
    end
  end

  assign scl_s = scl_sh_q[1];
  assign sda_s = sda_sh_q[1];
  assign scl_rise = scl_s & ~scl_sh_q[2];
  assign scl_fall = ~scl_s & scl_sh_q[2];
  assign start_det = scl_s & scl_sh_q[2] & sda_sh_q[2] & ~sda_s;
  assign stop_det = scl_s & scl_sh_q[2] & ~sda_sh_q[2] & sda_s;

  function automatic logic addr_hi_eq(input logic [7:0] a,
                                      input logic [7:0] b);
    addr_hi_eq = (a[7:1] == b[7:1]);
  endfunction

  // ----------------------------------------------------------------
  // slave receive / transmit sequencer
  // ----------------------------------------------------------------
  isa_pkg::isa_sl_state_t sl_st_q;
  isa_pkg::isa_phase_t ph_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] sr_q, tx_sh_q, buf_q, own_q;
  logic ack_q, acc_q, ua_pend_q, rd_q, hi_seen_q, mack_q;
  logic bf_q, ov_q, irq_q, ua_q;
  logic byte_done, accept, take, ua_set_ev, goes_tx, ninth_fall;
  logic bf_set;

  assign byte_done = (sl_st_q == isa_pkg::SL_RX) && scl_fall &&
                     (bit_cnt_q == `ISA_BYTE_BITS);
  assign ninth_fall = (sl_st_q == isa_pkg::SL_ACK) && scl_fall;

  always_comb begin
    accept = 1'b0;
    ua_set_ev = 1'b0;
    goes_tx = 1'b0;
    case (ph_q)
      isa_pkg::PH_A1: begin
        if (!ten_bit_mode) begin
          accept = addr_hi_eq(sr_q, own_q);
          goes_tx = sr_q[0];
        end else if (sr_q[7:3] == `ISA_TEN_PREFIX &&
                     addr_hi_eq(sr_q, own_q)) begin
          accept = !sr_q[0] || hi_seen_q;
          ua_set_ev = !sr_q[0];
          goes_tx = sr_q[0];
        end
      end
      isa_pkg::PH_A2: begin
        accept = (sr_q == own_q);
        ua_set_ev = 1'b1;
      end
      isa_pkg::PH_DAT: accept = !rd_q;
      default: accept = 1'b0;
    endcase
  end

  // clean take only when both flags were clear
  assign take = accept && !bf_q && !ov_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sl_st_q <= isa_pkg::SL_IDLE;
      ph_q <= isa_pkg::PH_A1;
      bit_cnt_q <= `ISA_BIT_ZERO;
      sr_q <= `ISA_BYTE_RST;
      tx_sh_q <= `ISA_BYTE_RST;
      ack_q <= 1'b0;
      acc_q <= 1'b0;
      ua_pend_q <= 1'b0;
      rd_q <= 1'b0;
      hi_seen_q <= 1'b0;
      mack_q <= 1'b0;
    end else if (!enable || stop_det) begin
      sl_st_q <= isa_pkg::SL_IDLE;
      ack_q <= 1'b0;
      hi_seen_q <= 1'b0;
    end else if (start_det) begin
      // start opens a fresh address byte
      sl_st_q <= isa_pkg::SL_RX;
      ph_q <= isa_pkg::PH_A1;
      bit_cnt_q <= `ISA_BIT_ZERO;
      ack_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      case (sl_st_q)
        isa_pkg::SL_RX: begin
          if (scl_rise && bit_cnt_q != `ISA_BYTE_BITS) begin
            sr_q <= {sr_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_done) begin
            // decide on the eighth falling edge
            if (!accept) begin
              sl_st_q <= isa_pkg::SL_IDLE;
            end else begin
              sl_st_q <= isa_pkg::SL_ACK;
              ack_q <= take;
              acc_q <= 1'b1;
              ua_pend_q <= ua_set_ev && take;
              if (ph_q == isa_pkg::PH_A1) begin
                rd_q <= goes_tx;
                ph_q <= (ten_bit_mode && !sr_q[0]) ? isa_pkg::PH_A2
                                                    : isa_pkg::PH_DAT;
              end else if (ph_q == isa_pkg::PH_A2) begin
                ph_q <= isa_pkg::PH_DAT;
                hi_seen_q <= 1'b1;
              end
            end
          end
        end
        isa_pkg::SL_ACK: begin
          if (scl_fall) begin
            // release data at end of ninth clock
            ack_q <= 1'b0;
            acc_q <= 1'b0;
            ua_pend_q <= 1'b0;
            bit_cnt_q <= `ISA_BIT_ZERO;
            if (rd_q && ack_q) begin
              sl_st_q <= isa_pkg::SL_TX;
              tx_sh_q <= tx_data;
            end else begin
              sl_st_q <= isa_pkg::SL_RX;
            end
          end
        end
        isa_pkg::SL_TX: begin
          if (scl_fall) begin
            if (bit_cnt_q == `ISA_LAST_TX_BIT) begin
              sl_st_q <= isa_pkg::SL_TXACK;
            end else begin
              tx_sh_q <= {tx_sh_q[6:0], 1'b1};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        isa_pkg::SL_TXACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_s;
          end else if (scl_fall) begin
            bit_cnt_q <= `ISA_BIT_ZERO;
            tx_sh_q <= tx_data;
            sl_st_q <= mack_q ? isa_pkg::SL_TX : isa_pkg::SL_IDLE;
          end
        end
        default: sl_st_q <= isa_pkg::SL_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // software flags; a hardware set wins over a same-cycle clear
  // ----------------------------------------------------------------
  // load and flag on the ninth falling edge
  assign bf_set = ninth_fall && ack_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      buf_q <= `ISA_BYTE_RST;
      bf_q <= 1'b0;
    end else begin
      if (buf_rd) bf_q <= 1'b0;
      if (bf_set) begin
        buf_q <= sr_q;
        bf_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ov_q <= 1'b0;
    end else begin
      if (ovf_clr) ov_q <= 1'b0;
      // byte arriving while buffer still full
      if (byte_done && accept && bf_q) ov_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      if (irq_clr) irq_q <= 1'b0;
      if (ninth_fall && acc_q) irq_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      own_q <= `ISA_ADDR_RST;
      ua_q <= 1'b0;
    end else begin
      // rewrite of own address clears update flag
      if (own_addr_wr) begin
        own_q <= own_addr_wdata;
        ua_q <= 1'b0;
      end
      if (ninth_fall && ua_pend_q) ua_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // master side: start, clock sync and arbitration
  // ----------------------------------------------------------------
  isa_pkg::isa_mst_state_t m_st_q;
  logic [7:0] m_tmr_q, m_sh_q;
  logic [3:0] m_bit_q;
  logic m_drv_q, m_adv_q, lost_q, m_lost_ev, m_sda_low;

  assign m_lost_ev = (m_st_q == isa_pkg::M_HIGH) && m_drv_q &&
                     (m_bit_q != `ISA_BYTE_BITS) && m_sh_q[7] && !sda_s;
  assign m_sda_low = m_drv_q && ((m_st_q == isa_pkg::M_START) ||
                     ((m_st_q != isa_pkg::M_IDLE) &&
                      (m_bit_q != `ISA_BYTE_BITS) && !m_sh_q[7]));

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      m_st_q <= isa_pkg::M_IDLE;
      m_tmr_q <= `ISA_TMR_ZERO;
      m_sh_q <= `ISA_BYTE_RST;
      m_bit_q <= `ISA_BIT_ZERO;
      m_drv_q <= 1'b0;
      m_adv_q <= 1'b0;
    end else begin
      case (m_st_q)
        isa_pkg::M_IDLE: begin
          // start only on a quiet bus, never against data
          if (mst_go && scl_s && sda_s && sl_st_q == isa_pkg::SL_IDLE) begin
            m_st_q <= isa_pkg::M_START;
            m_sh_q <= mst_byte;
            m_bit_q <= `ISA_BIT_ZERO;
            m_tmr_q <= `ISA_TMR_ZERO;
            m_drv_q <= 1'b1;
            m_adv_q <= 1'b0;
          end
        end
        isa_pkg::M_START: begin
          m_tmr_q <= m_tmr_q + `ISA_TMR_ONE;
          if (m_tmr_q == 8'(HIGH_CYC - 1)) begin
            m_st_q <= isa_pkg::M_LOW;
            m_tmr_q <= `ISA_TMR_ZERO;
          end
        end
        isa_pkg::M_LOW: begin
          // count own low period while holding clock
          m_tmr_q <= m_tmr_q + `ISA_TMR_ONE;
          if (m_tmr_q == `ISA_SHIFT_AT && m_adv_q) begin
            m_sh_q <= {m_sh_q[6:0], 1'b1};
            m_bit_q <= m_bit_q + 4'h1;
            m_adv_q <= 1'b0;
          end
          if (m_tmr_q == 8'(LOW_CYC - 1)) m_st_q <= isa_pkg::M_WAITH;
        end
        isa_pkg::M_WAITH: begin
          // wait until the wired clock is really high
          if (scl_s) begin
            m_st_q <= isa_pkg::M_HIGH;
            m_tmr_q <= `ISA_TMR_ZERO;
          end
        end
        isa_pkg::M_HIGH: begin
          if (m_lost_ev) m_drv_q <= 1'b0;
          m_tmr_q <= m_tmr_q + `ISA_TMR_ONE;
          if (!scl_s) begin
            m_st_q <= isa_pkg::M_LOW;
            m_tmr_q <= `ISA_TMR_ZERO;
            m_adv_q <= 1'b1;
          end else if (m_tmr_q == 8'(HIGH_CYC - 1)) begin
            // clocks run to the byte end even after loss
            m_tmr_q <= `ISA_TMR_ZERO;
            if (m_bit_q == `ISA_BYTE_BITS) begin
              m_st_q <= isa_pkg::M_IDLE;
              m_drv_q <= 1'b0;
            end else begin
              m_st_q <= isa_pkg::M_LOW;
              m_adv_q <= 1'b1;
            end
          end
        end
        default: m_st_q <= isa_pkg::M_IDLE;
      endcase
    end
  end

  // loss leaves the slave sequencer receiving untouched
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lost_q <= 1'b0;
    end else if (mst_go && m_st_q == isa_pkg::M_IDLE) begin
      lost_q <= 1'b0;
    end else if (m_lost_ev) begin
      lost_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pin drive and outputs
  // ----------------------------------------------------------------
  // data pin overrides the input direction when needed
  assign sda_oe = (sl_st_q == isa_pkg::SL_ACK && ack_q) ||
                  (sl_st_q == isa_pkg::SL_TX && !tx_sh_q[7]) || m_sda_low;
  // stretch during address update and own low period
  assign scl_oe = ua_q || (m_st_q == isa_pkg::M_LOW);
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign receive_buffer = buf_q;
  assign own_address_register = own_q;
  assign buffer_full_flag = bf_q;
  assign receive_overflow_flag = ov_q;
  assign serial_port_irq_flag = irq_q;
  assign address_update_flag = ua_q;
  assign read_mode = rd_q;
  assign mst_busy = (m_st_q != isa_pkg::M_IDLE);
  assign arb_lost = lost_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  ack_hold_a: assert property (
    (sl_st_q == isa_pkg::SL_ACK && ack_q && scl_rise && enable)
      |=> (sl_st_q == isa_pkg::SL_ACK && sda_oe))
    else $error("ack not held during ninth high");
  full_nack_a: assert property (
    (byte_done && (bf_q || ov_q)) |=> !ack_q ##0 !bf_set)
    else $error("acknowledged while buffer full or overflow");
  buf_load_a: assert property (
    bf_set |=> (bf_q && buf_q == $past(sr_q)))
    else $error("buffer not loaded after acknowledge");
  irq_ninth_a: assert property (
    (ninth_fall && acc_q && !irq_clr) |=> irq_q)
    else $error("irq not set on ninth falling edge");
  bf_clear_a: assert property (
    (buf_rd && !bf_set) |=> !bf_q)
    else $error("buffer-full not cleared by read");
  ov_sticky_a: assert property (
    (ov_q && !ovf_clr) |=> ov_q)
    else $error("overflow cleared without software");
  stretch_hold_a: assert property (
    (ninth_fall && ua_pend_q) |=> (ua_q && scl_oe))
    else $error("clock not stretched during address update");
  rise_sample_a: assert property (
    (sl_st_q == isa_pkg::SL_RX && scl_rise && !start_det && !stop_det &&
     enable && bit_cnt_q != `ISA_BYTE_BITS) |=> sr_q[0] == $past(sda_s))
    else $error("bit not sampled on rising clock");
  addr_miss_a: assert property (
    (byte_done && !accept && enable && !stop_det)
      |=> sl_st_q == isa_pkg::SL_IDLE)
    else $error("mismatched address not dropped");
  tx_drive_a: assert property (
    (sl_st_q == isa_pkg::SL_ACK && scl_fall && rd_q && ack_q && enable)
      |=> (sl_st_q == isa_pkg::SL_TX && tx_sh_q == $past(tx_data) &&
           (tx_sh_q[7] || sda_oe)))
    else $error("transmit bit not driven");
  lost_drop_a: assert property (
    m_lost_ev |=> (!m_drv_q && arb_lost))
    else $error("loser kept driving data");
  low_sync_a: assert property (
    (m_st_q == isa_pkg::M_LOW && m_tmr_q < 8'(LOW_CYC - 1))
      |=> (m_st_q == isa_pkg::M_LOW && scl_oe))
    else $error("clock not held low in low period");
  wait_high_a: assert property (
    (m_st_q == isa_pkg::M_WAITH && !scl_s)
      |=> m_st_q == isa_pkg::M_WAITH)
    else $error("left wait state before clock rose");

  addr_ack_c: cover property (byte_done && take ##[1:200] ninth_fall);
  refuse_c: cover property (byte_done && accept && bf_q);
  tx_byte_c: cover property (sl_st_q == isa_pkg::SL_TXACK);
  arb_loss_c: cover property (m_lost_ev);
endmodule
`default_nettype wire

// file: dv/isa_mst_model.sv
// bus master model for the two-wire slave, driving pull-down enables
// assumes pull-ups on both wires: a released line reads high
`timescale 1ns/10ps
`default_nettype none
module isa_mst_model (
  // clock
  input wire logic sys_clk,
  // resolved wire levels
  input wire logic scl_w,
  input wire logic sda_w,
  // pull-down enables, high pulls the line low
  output logic scl_pd,
  output logic sda_pd
);
  initial begin
    scl_pd = 1'b0;
    sda_pd = 1'b0;
  end
  // ----------
  // line timing
  // ----------
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic rise();
    int i;
    scl_pd <= 1'b0;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (scl_w !== 1'b1 && i < 30000);
    wt(4);
  endtask
  task automatic bit_io(input logic b, output logic r);
    wt(1);
    sda_pd <= ~b;
    wt(3);
    rise();
    r = sda_w;
    scl_pd <= 1'b1;
  endtask
  // ----------
  // framing
  // ----------
  task automatic start();
    if (scl_pd) begin
      wt(1);
      sda_pd <= 1'b0;
      wt(3);
      rise();
    end
    sda_pd <= 1'b1;
    wt(4);
    scl_pd <= 1'b1;
  endtask
  task automatic stop();
    wt(1);
    sda_pd <= 1'b1;
    wt(3);
    rise();
    sda_pd <= 1'b0;
    wt(4);
  endtask
  task automatic xfer(input logic [7:0] b, input logic ab,
                      output logic [7:0] r, output logic ar);
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r[i]);
    bit_io(ab, ar);
  endtask
  task automatic pull(input logic c, input logic v);
    if (c)
      sda_pd <= v;
    else
      scl_pd <= v;
  endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
// self-checking bench for the two-wire slave with arbitration
// assumes pull-ups on both wires and the master model beside it
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic sys_rst, enable, ten_bit_mode, own_addr_wr, buf_rd;
  logic ovf_clr, irq_clr, mst_go, scl_out, scl_oe, sda_out, sda_oe;
  logic bf, ov, irq, ua, read_mode, mst_busy, arb_lost, scl_pd, sda_pd;
  logic scl_p, e_bf, e_ov, e_ua, ar;
  logic [7:0] own_addr_wdata, tx_data, mst_byte, rbuf, own_q, e_buf;
  logic [7:0] rises, r, l;
  logic [6:0] a;
  int mismatches, compares;
  wire logic scl_w, sda_w;
  assign scl_w = ~((scl_oe & ~scl_out) | scl_pd);
  assign sda_w = ~((sda_oe & ~sda_out) | sda_pd);
  isa_slave #(.LOW_CYC(4), .HIGH_CYC(4)) dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .enable(enable),
    .ten_bit_mode(ten_bit_mode), .own_addr_wr(own_addr_wr),
    .own_addr_wdata(own_addr_wdata), .buf_rd(buf_rd), .ovf_clr(ovf_clr),
    .irq_clr(irq_clr), .tx_data(tx_data), .receive_buffer(rbuf),
    .own_address_register(own_q), .buffer_full_flag(bf),
    .receive_overflow_flag(ov), .serial_port_irq_flag(irq),
    .address_update_flag(ua), .read_mode(read_mode), .mst_go(mst_go),
    .mst_byte(mst_byte), .mst_busy(mst_busy), .arb_lost(arb_lost));
  isa_mst_model mdl_u (.sys_clk(sys_clk), .scl_w(scl_w), .sda_w(sda_w),
    .scl_pd(scl_pd), .sda_pd(sda_pd));
  always #50 sys_clk = ~sys_clk;
  // clock pulses made while our master runs
  always @(posedge sys_clk) begin
    scl_p <= scl_w;
    if (mst_go)
      rises <= 8'h00;
    else if (scl_w && !scl_p && mst_busy)
      rises <= rises + 8'h01;
  end
  // ----------
  // checking
  // ----------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic take(input logic f, input logic o);
    return !(f || o);
  endfunction
  // ----------
  // software and bus steps
  // ----------
  task automatic sw(input int k);
    @(posedge sys_clk);
    {buf_rd, ovf_clr, irq_clr, own_addr_wr} <= 4'h8 >> k;
    @(posedge sys_clk);
    {buf_rd, ovf_clr, irq_clr, own_addr_wr} <= 4'h0;
    repeat (2) @(posedge sys_clk);
    if (k == 0)
      e_bf = 1'b0;
    if (k == 1)
      e_ov = 1'b0;
    if (k == 3)
      e_ua = 1'b0;
    chk({5'h0, bf, ov, ua}, {5'h0, e_bf, e_ov, e_ua});
  endtask
  task automatic rx(input logic [7:0] d, input logic u);
    logic t;
    sw(2);
    t = take(e_bf, e_ov);
    mdl_u.xfer(d, 1'b1, r, ar);
    mdl_u.wt(6);
    e_ov = e_ov | e_bf;
    if (t) begin
      e_buf = d;
      e_bf = 1'b1;
    end
    e_ua = u;
    chk({7'h0, ar}, {7'h0, !t});
    chk(rbuf, e_buf);
    chk({4'h0, bf, ov, irq, ua},
        {4'h0, e_bf, e_ov, 1'b1, e_ua});
  endtask
  task automatic mrun(input logic c);
    int i;
    mst_byte <= c ? 8'hff : {~a, 1'b0};
    mst_go <= 1'b1;
    @(posedge sys_clk);
    mst_go <= 1'b0;
    i = 0;
    while (scl_w !== 1'b0 && i < 200) begin
      @(posedge sys_clk);
      i++;
    end
    mdl_u.pull(c, 1'b1);
    if (!c) begin
      mdl_u.wt(30);
      mdl_u.pull(c, 1'b0);
    end
    i = 0;
    while (mst_busy !== 1'b0 && i < 2000) begin
      @(posedge sys_clk);
      i++;
    end
    mdl_u.wt(4);
    mdl_u.pull(c, 1'b0);
    mdl_u.wt(20);
    chk({6'h0, mst_busy, arb_lost}, {7'h0, c});
    chk(rises, 8'h09);
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    end_of_test();
  end
  // ----------
  // main sequence
  // ----------
  initial begin
    sys_rst = 1'b1;
    {enable, ten_bit_mode, own_addr_wr, buf_rd, ovf_clr, irq_clr} = 6'h0;
    {mst_go, e_bf, e_ov, e_ua} = 4'h0;
    {own_addr_wdata, tx_data, mst_byte, e_buf} = 32'h0;
    mismatches = 0;
    compares = 0;
    void'($urandom(32'h0a05bc01));
    a = 7'($urandom()) | 7'h01;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({scl_out, sda_out, bf, ov, irq, ua, mst_busy, arb_lost},
        8'h00);
    chk(rbuf | own_q, 8'h00);
    chk({6'h0, scl_oe, sda_oe}, 8'h00);
    own_addr_wdata <= {a, 1'b0};
    enable <= 1'b1;
    sw(3);
    chk(own_q, {a, 1'b0});
    mrun(1'b0);
    mrun(1'b1);
    mdl_u.start();
    rx({a, 1'b0}, 1'b0);
    sw(0);
    rx(8'($urandom()), 1'b0);
    rx(8'($urandom()), 1'b0);
    sw(0);
    rx(8'($urandom()), 1'b0);
    sw(1);
    rx(8'($urandom()), 1'b0);
    mdl_u.stop();
    sw(0);
    for (int k = 0; k < 2; k++) begin
      sw(2);
      enable <= k[0];
      mdl_u.start();
      mdl_u.xfer({a ^ {k[0], 6'h0}, 1'b0}, 1'b1, r, ar);
      mdl_u.wt(6);
      chk({6'h0, ar, irq}, 8'h02);
      mdl_u.stop();
    end
    ten_bit_mode <= 1'b1;
    l = 8'($urandom());
    own_addr_wdata <= {5'h1e, a[1:0], 1'b0};
    sw(3);
    mdl_u.start();
    rx({5'h1e, a[1:0], 1'b0}, 1'b1);
    own_addr_wdata <= l;
    sw(3);
    sw(0);
    rx(l, 1'b1);
    own_addr_wdata <= {5'h1e, a[1:0], 1'b0};
    sw(3);
    sw(0);
    tx_data <= 8'($urandom());
    mdl_u.start();
    rx({5'h1e, a[1:0], 1'b1}, 1'b0);
    chk({7'h0, read_mode}, 8'h01);
    mdl_u.xfer(8'hff, 1'b1, r, ar);
    chk(r, tx_data);
    chk({7'h0, ar}, 8'h01);
    mdl_u.stop();
    end_of_test();
  end
endmodule
`default_nettype wire
